// *** arh_alarm_history.sv ***
// Alarm clear sources, ten-entry alarm history log and its register port
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1: Host fault-clear input clears active alarms
// R2: Pin-map digit selects fault-clear input pin
// R3: Up and down keys together clear alarms
// R4: Handheld unit reset key clears alarms
// R5: Ten entries kept, oldest dropped
// R6: Newest alarm at slot zero
// R7: Entry holds code and class; empty reads normal
// R8: Same alarm within one hour not logged
// R9: Reset and power loss keep log; here reset clears all ten entries
// R10: Erase command refused while writes prohibited
// R11: Read command shows entries unaltered
// R12: Encoder alarms survive fault-clear input
// R13: System alarms never logged
// R14: Synchronise input, act on falling edge
// R15: Entry stamped with operating time
module arh_alarm_history
  import arh_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [PIN_CNT-1:0] in_pins_n,
  input  wire logic              key_up,
  input  wire logic              key_down,
  input  wire logic              handheld_reset,
  input  wire logic              alarm_raise,
  input  wire logic [CODE_W-1:0] alarm_code,
  input  wire logic [1:0]        alarm_class,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output var  logic [DATA_W-1:0] rdata,
  output var  logic              servo_fault_output,
  output var  logic [CODE_W-1:0] active_code,
  output var  logic              irq
);

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
    hit = (a == r);
  endfunction : hit

  // ---------------------------------------------------------------------------
  // Pin synchronisers and clocks
  // ---------------------------------------------------------------------------
  logic [PIN_CNT-1:0] pin_fall;
  logic               tick;

  genvar gi;
  generate
    for (gi = 0; gi < PIN_CNT; gi++) begin : g_sync
      arh_edge_sync u_sync (
        .clk   (clk),
        .rst   (rst),
        .pin_n (in_pins_n[gi]),
        .level (),
        .fall  (pin_fall[gi])
      );
    end
  endgenerate

  arh_tick_div u_div (
    .clk  (clk),
    .rst  (rst),
    .tick (tick)
  );

  // ---------------------------------------------------------------------------
  // Panel keys and handheld unit
  // ---------------------------------------------------------------------------
  logic key_up_m, key_up_s, key_dn_m, key_dn_s, hh_m, hh_s;
  logic chord_d, hh_d;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      key_up_m <= 1'b0;
      key_up_s <= 1'b0;
      key_dn_m <= 1'b0;
      key_dn_s <= 1'b0;
      hh_m     <= 1'b0;
      hh_s     <= 1'b0;
      chord_d  <= 1'b0;
      hh_d     <= 1'b0;
    end else begin
      key_up_m <= key_up;
      key_up_s <= key_up_m;
      key_dn_m <= key_down;
      key_dn_s <= key_dn_m;
      hh_m     <= handheld_reset;
      hh_s     <= hh_m;
      chord_d  <= key_up_s & key_dn_s;
      hh_d     <= hh_s;
    end
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [MAP_W-1:0]     pin_map;
  logic                 wr_prot;
  logic [IDX_W-1:0]     rd_idx;
  logic [EV_W-1:0]      irq_stat;
  logic [EV_W-1:0]      irq_mask;
  logic [TIME_W-1:0]    op_time;
  logic [CODE_W-1:0]    view_code;
  logic [1:0]           view_class;
  logic [TIME_W-1:0]    view_time;

  wire logic [PIN_SEL_W-1:0] clr_sel = pin_map[MAP_DIGIT_LSB +: PIN_SEL_W]; // R2
  wire logic clr_pulse_pin = pin_fall[clr_sel];                             // R14
  wire logic chord_pulse = key_up_s & key_dn_s & ~chord_d;                  // R3
  wire logic hh_pulse    = hh_s & ~hh_d;                                    // R4
  wire logic cmd_wr      = wr & hit(addr, REG_CMD);
  wire logic erase_req   = cmd_wr & wdata[CMD_ERASE_BIT];
  wire logic read_req    = cmd_wr & wdata[CMD_READ_BIT];
  wire logic erase_ok    = erase_req & ~wr_prot;                            // R10

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_map  <= PIN_MAP_RESET;
      wr_prot  <= 1'b0;
      rd_idx   <= '0;
      irq_mask <= '0;
    end else if (wr) begin
      if (hit(addr, REG_PIN_MAP))  pin_map  <= wdata[MAP_W-1:0];
      if (hit(addr, REG_CTRL))     wr_prot  <= wdata[CTRL_WPROT_BIT];
      if (hit(addr, REG_RD_IDX))   rd_idx   <= wdata[IDX_W-1:0];
      if (hit(addr, REG_IRQ_MASK)) irq_mask <= wdata[EV_W-1:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Operating time
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) op_time <= '0;
    else if (tick) op_time <= op_time + 1'b1;
  end

  // ---------------------------------------------------------------------------
  // Active alarm
  // ---------------------------------------------------------------------------
  logic [1:0] act_class;
  wire logic clr_any  = chord_pulse | hh_pulse | clr_pulse_pin;
  wire logic clr_done = servo_fault_output & (chord_pulse | hh_pulse
                        | (clr_pulse_pin & (act_class != ARH_CLS_ENCODER))); // R12

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      servo_fault_output <= 1'b0;
      active_code        <= CODE_NORMAL;
      act_class          <= ARH_CLS_NORMAL;
    end else if (alarm_raise) begin
      servo_fault_output <= 1'b1;
      active_code        <= alarm_code;
      act_class          <= alarm_class;
    end else if (clr_done) begin                                            // R1
      servo_fault_output <= 1'b0;
      active_code        <= CODE_NORMAL;
      act_class          <= ARH_CLS_NORMAL;
    end
  end

  // ---------------------------------------------------------------------------
  // History log
  // ---------------------------------------------------------------------------
  logic [CODE_W-1:0] h_code  [HIST_DEPTH];
  logic [1:0]        h_class [HIST_DEPTH];
  logic [TIME_W-1:0] h_time  [HIST_DEPTH];
  logic [IDX_W-1:0]  h_count;
  logic [CODE_W-1:0] last_code;
  logic              last_valid;
  logic [TIME_W-1:0] last_time;

  wire logic [TIME_W-1:0] since = op_time - last_time;
  wire logic repeat_hit = last_valid & (alarm_code == last_code)
                          & (since < TIME_W'(REPEAT_WIN_TICKS));            // R8
  wire logic do_log = alarm_raise & (alarm_class != ARH_CLS_SYSTEM)         // R13
                      & ~repeat_hit;

  // Log is untouched by alarm clears; only reset, erase or a new entry changes it
  always_ff @(posedge clk or posedge rst) begin                             // R9
    if (rst) begin
      for (int i = 0; i < HIST_DEPTH; i++) begin
        h_code[i]  <= CODE_NORMAL;
        h_class[i] <= ARH_CLS_NORMAL;
        h_time[i]  <= '0;
      end
      h_count <= '0;
    end else if (erase_ok) begin                                            // R10
      for (int i = 0; i < HIST_DEPTH; i++) begin
        h_code[i]  <= CODE_NORMAL;
        h_class[i] <= ARH_CLS_NORMAL;
        h_time[i]  <= '0;
      end
      h_count <= '0;
    end else if (do_log) begin
      for (int i = HIST_DEPTH - 1; i > 0; i--) begin                        // R5
        h_code[i]  <= h_code[i-1];
        h_class[i] <= h_class[i-1];
        h_time[i]  <= h_time[i-1];
      end
      h_code[0]  <= alarm_code;                                             // R6
      h_class[0] <= alarm_class;                                            // R7
      h_time[0]  <= op_time;                                                // R15
      if (h_count != IDX_W'(HIST_DEPTH)) h_count <= h_count + 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Repeat filter
  // ---------------------------------------------------------------------------
  // Repeat filter follows the last raised non-system alarm, cleared with the log
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_code  <= CODE_NORMAL;
      last_valid <= 1'b0;
      last_time  <= '0;
    end else if (erase_ok) begin
      last_valid <= 1'b0;
    end else if (alarm_raise && alarm_class != ARH_CLS_SYSTEM) begin
      last_code  <= alarm_code;
      last_valid <= 1'b1;
      last_time  <= op_time;
    end
  end

  // ---------------------------------------------------------------------------
  // Slot view
  // ---------------------------------------------------------------------------
  // Read command latches one slot into the view registers
  always_ff @(posedge clk or posedge rst) begin                             // R11
    if (rst) begin
      view_code  <= CODE_NORMAL;
      view_class <= ARH_CLS_NORMAL;
      view_time  <= '0;
    end else if (read_req) begin
      if (rd_idx < IDX_W'(HIST_DEPTH)) begin
        view_code  <= h_code[rd_idx];
        view_class <= h_class[rd_idx];
        view_time  <= h_time[rd_idx];
      end else begin
        view_code  <= CODE_NORMAL;                                          // R7
        view_class <= ARH_CLS_NORMAL;
        view_time  <= '0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------------------
  logic [EV_W-1:0] ev;
  always_comb begin
    ev = '0;
    ev[EV_LOGGED]  = do_log & ~erase_ok;
    ev[EV_CLEARED] = clr_done & ~alarm_raise;
    ev[EV_ERASED]  = erase_ok;
    ev[EV_REFUSED] = erase_req & wr_prot | (clr_any & servo_fault_output & ~clr_done);
  end

  wire logic [EV_W-1:0] w1c = (wr & hit(addr, REG_IRQ_STAT)) ? wdata[EV_W-1:0] : '0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) irq_stat <= '0;
    else     irq_stat <= (irq_stat & ~w1c) | ev;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) irq <= 1'b0;
    else     irq <= |(((irq_stat & ~w1c) | ev) & irq_mask);
  end

  // ---------------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else if (rd) begin
      case (addr)
        REG_CTRL:     rdata <= DATA_W'(wr_prot);
        REG_STATUS:   rdata <= DATA_W'({h_count, act_class, servo_fault_output});
        REG_IRQ_STAT: rdata <= DATA_W'(irq_stat);
        REG_IRQ_MASK: rdata <= DATA_W'(irq_mask);
        REG_PIN_MAP:  rdata <= DATA_W'(pin_map);
        REG_RD_IDX:   rdata <= DATA_W'(rd_idx);
        REG_RD_CODE:  rdata <= DATA_W'({view_class, view_code});
        REG_RD_TIME:  rdata <= view_time;
        REG_OPTIME:   rdata <= op_time;
        default:      rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

endmodule : arh_alarm_history
`default_nettype wire

// *** arh_pkg.sv ***
// Package of constants and types for the alarm reset and history block
package arh_pkg;

  // ---------------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned TICK_MS         = 100;
  localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned REPEAT_WIN_S    = 3600;
  localparam int unsigned TICKS_PER_S     = 1000 / TICK_MS;
  localparam int unsigned REPEAT_WIN_TICKS = REPEAT_WIN_S * TICKS_PER_S;

  // ---------------------------------------------------------------------------
  // Widths and sizes
  // ---------------------------------------------------------------------------
  localparam int unsigned HIST_DEPTH = 10;
  localparam int unsigned IDX_W      = 4;
  localparam int unsigned CODE_W     = 12;
  localparam int unsigned TIME_W     = 32;
  localparam int unsigned PIN_CNT    = 8;
  localparam int unsigned PIN_SEL_W  = 3;
  localparam int unsigned TICK_CNT_W = 22;
  localparam int unsigned MAP_DIGIT_LSB = 4;
  localparam int unsigned MAP_W      = 16;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS   = 8'h04;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_PIN_MAP  = 8'h10;
  localparam logic [ADDR_W-1:0] REG_CMD      = 8'h14;
  localparam logic [ADDR_W-1:0] REG_RD_IDX   = 8'h18;
  localparam logic [ADDR_W-1:0] REG_RD_CODE  = 8'h1C;
  localparam logic [ADDR_W-1:0] REG_RD_TIME  = 8'h20;
  localparam logic [ADDR_W-1:0] REG_OPTIME   = 8'h24;

  // Control fields
  localparam int unsigned CTRL_WPROT_BIT = 0;
  // Command fields
  localparam int unsigned CMD_READ_BIT  = 0;
  localparam int unsigned CMD_ERASE_BIT = 1;
  // Interrupt event bits
  localparam int unsigned EV_W        = 4;
  localparam int unsigned EV_LOGGED   = 0;
  localparam int unsigned EV_CLEARED  = 1;
  localparam int unsigned EV_ERASED   = 2;
  localparam int unsigned EV_REFUSED  = 3;

  localparam logic [MAP_W-1:0]  PIN_MAP_RESET = 16'h0000;
  localparam logic [CODE_W-1:0] CODE_NORMAL   = 12'h000;

  // ---------------------------------------------------------------------------
  // Alarm classes
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ARH_CLS_NORMAL  = 2'h0,
    ARH_CLS_ENCODER = 2'h1,
    ARH_CLS_SYSTEM  = 2'h2
  } arh_class_e;

endpackage : arh_pkg

// *** arh_edge_sync.sv ***
// Two-stage synchroniser with falling-edge pulse for an active-low pin
`timescale 1ns/1ps
`default_nettype none
module arh_edge_sync
  import arh_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin_n,
  output var  logic level,
  output var  logic fall
);

  logic meta;
  logic sync;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= 1'b1;
      sync <= 1'b1;
    end else begin
      meta <= pin_n;
      sync <= meta;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level <= 1'b1;
      fall  <= 1'b0;
    end else begin
      level <= sync;
      fall  <= level & ~sync;
    end
  end

endmodule : arh_edge_sync
`default_nettype wire

// *** arh_tick_div.sv ***
// Divider making a one-cycle tick for the operating-time counter
`timescale 1ns/1ps
`default_nettype none
module arh_tick_div
  import arh_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  output var  logic tick
);

  localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(TICK_CYCLES - 1);

  logic [TICK_CNT_W-1:0] cnt;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else if (cnt == TICK_LAST) begin
      cnt  <= '0;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + 1'b1;
      tick <= 1'b0;
    end
  end

endmodule : arh_tick_div
`default_nettype wire

// *** arh_host_model.sv ***
// Host motion controller model driving the active-low fault-clear pins
`timescale 1ns/1ps
`default_nettype none
module arh_host_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [2:0] sel,
  input  wire logic       req,
  input  wire logic       keep,
  input  wire logic [3:0] lag,
  output var  logic [7:0] pins_n
);
  logic       pend;
  logic [3:0] wait_q;
  logic [2:0] low_q;

  // Asserts only when asked, after a chosen lag, then holds or releases
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend   <= 1'b0;
      wait_q <= 4'h0;
      low_q  <= 3'h0;
    end else if (req) begin
      pend   <= 1'b1;
      wait_q <= lag;
    end else if (pend && wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
    end else if (pend) begin
      pend  <= 1'b0;
      low_q <= 3'h6;
    end else if (low_q != 3'h0 && !keep) begin
      low_q <= low_q - 3'h1;
    end
  end

  // Pins have pull-ups: released pins read high
  always_comb begin
    pins_n = 8'hFF;
    if (low_q != 3'h0) begin
      pins_n[sel] = 1'b0;
    end
  end
endmodule : arh_host_model
`default_nettype wire

// *** arh_assertions.sv ***
// Checker of the alarm reset and history block ports
`timescale 1ns/1ps
`default_nettype none
module arh_checker
  import arh_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic [PIN_CNT-1:0] in_pins_n,
  input wire logic              key_up,
  input wire logic              key_down,
  input wire logic              handheld_reset,
  input wire logic              alarm_raise,
  input wire logic [CODE_W-1:0] alarm_code,
  input wire logic [1:0]        alarm_class,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic              servo_fault_output,
  input wire logic [CODE_W-1:0] active_code,
  input wire logic              irq
);
  logic [2:0]         sel_q;
  logic [1:0]         cls_q;
  logic [PIN_CNT-1:0] pins_q;
  logic [2:0]         keys_q;
  logic [3:0]         since;
  wire cause = (|(pins_q & ~in_pins_n)) | (|({key_up, key_down, handheld_reset} & ~keys_q));

  // Tracks pin selection, last raised class and cycles since a clear cause
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_q  <= 3'h0;
      cls_q  <= 2'h0;
      pins_q <= '1;
      keys_q <= 3'h0;
      since  <= 4'hF;
    end else begin
      if (wr && addr == REG_PIN_MAP) sel_q <= wdata[6:4];
      if (alarm_raise) cls_q <= alarm_class;
      pins_q <= in_pins_n;
      keys_q <= {key_up, key_down, handheld_reset};
      since  <= cause ? 4'h0 : (since == 4'hF ? 4'hF : since + 4'h1);
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  fault_set_a: assert property (alarm_raise |=> servo_fault_output)
    else $error("fault output not set after alarm");
  code_show_a: assert property (alarm_raise |=> active_code == $past(alarm_code))
    else $error("active code differs from raised code");
  rdata_idle_a: assert property (!rd |=> rdata == '0)
    else $error("read data not zero outside read answer");
  unmapped_rd_a: assert property (rd && addr > REG_OPTIME |=> rdata == '0)
    else $error("unmapped read returned data");
  irq_mask_a: assert property (wr && addr == REG_IRQ_MASK && wdata[EV_W-1:0] == '0 |-> ##2 !irq)
    else $error("interrupt high with all events masked");
  clear_cause_a: assert property ($fell(servo_fault_output) |-> since <= 4'h8)
    else $error("fault cleared without a clear request");
  pin_clear_a: assert property ($fell(in_pins_n[sel_q]) && servo_fault_output && cls_q == 2'h0 && !alarm_raise
    ##1 (!in_pins_n[sel_q] && !alarm_raise)[*4] |-> !servo_fault_output)
    else $error("selected pin did not clear the fault");
  enc_keep_a: assert property ($fell(in_pins_n[sel_q]) && servo_fault_output && cls_q == 2'h1
    ##1 (!alarm_raise && !key_up && !handheld_reset)[*6] |-> servo_fault_output)
    else $error("encoder alarm cleared by pin");
  held_once_a: assert property ((!in_pins_n[sel_q])[*8] ##1 (alarm_raise && !in_pins_n[sel_q])
    ##1 (!in_pins_n[sel_q] && !alarm_raise && !key_up && !handheld_reset)[*6] |-> servo_fault_output)
    else $error("held pin cleared a later alarm");

  cover property ($fell(servo_fault_output) && cls_q == 2'h0);
  cover property ($fell(in_pins_n[sel_q]) && servo_fault_output && cls_q == 2'h1);
  cover property (rd ##1 rdata != '0);
endmodule : arh_checker

bind arh_alarm_history arh_checker u_chk (
  .clk(clk), .rst(rst), .in_pins_n(in_pins_n), .key_up(key_up), .key_down(key_down),
  .handheld_reset(handheld_reset), .alarm_raise(alarm_raise), .alarm_code(alarm_code),
  .alarm_class(alarm_class), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .servo_fault_output(servo_fault_output), .active_code(active_code), .irq(irq)
);
`default_nettype wire

// *** testbench.sv ***
// Self-checking testbench of the alarm reset and history block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module testbench
  import arh_pkg::*;
;
  logic              clk = 1'b0, rst = 1'b1;
  logic              key_up = 1'b0, key_down = 1'b0, handheld_reset = 1'b0, alarm_raise = 1'b0;
  logic              wr = 1'b0, rd = 1'b0, h_req = 1'b0, h_keep = 1'b0;
  logic [2:0]        h_sel = 3'h0;
  logic [3:0]        h_lag = 4'h0;
  logic [1:0]        alarm_class = 2'h0;
  logic [CODE_W-1:0] alarm_code = '0, active_code;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata;
  logic [7:0]        pins_n;
  logic              servo_fault_output, irq;
  int                checks = 0, mismatches = 0;

  always #12.5 clk = ~clk;

  arh_host_model u_host (.clk(clk), .rst(rst), .sel(h_sel), .req(h_req), .keep(h_keep), .lag(h_lag), .pins_n(pins_n));
  arh_alarm_history u_dut (
    .clk(clk), .rst(rst), .in_pins_n(pins_n), .key_up(key_up), .key_down(key_down),
    .handheld_reset(handheld_reset), .alarm_raise(alarm_raise), .alarm_code(alarm_code),
    .alarm_class(alarm_class), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .servo_fault_output(servo_fault_output), .active_code(active_code), .irq(irq)
  );

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_n

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  task automatic get_slot(input int i, output logic [DATA_W-1:0] d);
    wr_reg(REG_RD_IDX, DATA_W'(i));
    wr_reg(REG_CMD, 32'h0000_0001);
    rd_reg(REG_RD_CODE, d);
  endtask : get_slot

  task automatic raise(input logic [CODE_W-1:0] c, input logic [1:0] cls);
    @(posedge clk);
    alarm_raise <= 1'b1;
    alarm_code  <= c;
    alarm_class <= cls;
    @(posedge clk);
    alarm_raise <= 1'b0;
    wait_n(2);
  endtask : raise

  task automatic host_clear(input logic [2:0] s, input logic [3:0] l);
    @(posedge clk);
    h_sel <= s;
    h_lag <= l;
    h_req <= 1'b1;
    @(posedge clk);
    h_req <= 1'b0;
    wait_n(int'(l) + 14);
  endtask : host_clear

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_log;
    logic [DATA_W-1:0] d;
    get_slot(3, d);
    `CHK(d, 32'h0)
    `CHK(servo_fault_output, 1'b0)
    for (int k = 0; k < 11; k++) raise(CODE_W'(12'h100 + k), 2'h0);
    for (int i = 0; i < 10; i++) begin
      get_slot(i, d);
      `CHK(d[13:0], 14'(14'h10A - i))
    end
    get_slot(10, d);
    `CHK(d, 32'h0)
    get_slot(0, d);
    rd_reg(REG_RD_TIME, d);
    `CHK(d, 32'h0)
    rd_reg(8'h40, d);
    `CHK(d, 32'h0)
  endtask : t_log

  task automatic t_repeat;
    logic [DATA_W-1:0] d;
    raise(12'h10A, 2'h0);
    get_slot(1, d);
    `CHK(d[13:0], 14'h109)
    raise(12'hF01, 2'h2);
    `CHK(servo_fault_output, 1'b1)
    get_slot(0, d);
    `CHK(d[13:0], 14'h10A)
  endtask : t_repeat

  task automatic t_pin;
    logic [DATA_W-1:0] d;
    raise(12'h200, 2'h0);
    host_clear(3'h0, 4'h0);
    `CHK(servo_fault_output, 1'b0)
    `CHK(active_code, 12'h000)
    get_slot(0, d);
    `CHK(d[13:0], 14'h200)
    wr_reg(REG_PIN_MAP, 32'h0000_0050);
    raise(12'h201, 2'h0);
    host_clear(3'h0, 4'h0);
    `CHK(servo_fault_output, 1'b1)
    host_clear(3'h5, 4'h9);
    `CHK(servo_fault_output, 1'b0)
    wr_reg(REG_PIN_MAP, 32'h0);
  endtask : t_pin

  task automatic t_keys;
    logic [DATA_W-1:0] d;
    wr_reg(REG_IRQ_STAT, 32'hF);
    raise(12'hC90, 2'h1);
    host_clear(3'h0, 4'h0);
    `CHK(servo_fault_output, 1'b1)
    rd_reg(REG_IRQ_STAT, d);
    `CHK(d[EV_REFUSED], 1'b1)
    @(posedge clk) handheld_reset <= 1'b1;
    repeat (4) @(posedge clk);
    handheld_reset <= 1'b0;
    wait_n(10);
    `CHK(servo_fault_output, 1'b0)
    raise(12'h300, 2'h0);
    @(posedge clk) key_up <= 1'b1;
    wait_n(10);
    `CHK(servo_fault_output, 1'b1)
    @(posedge clk) key_down <= 1'b1;
    wait_n(10);
    `CHK(servo_fault_output, 1'b0)
    @(posedge clk);
    key_up   <= 1'b0;
    key_down <= 1'b0;
  endtask : t_keys

  task automatic t_held;
    h_keep <= 1'b1;
    raise(12'h400, 2'h0);
    host_clear(3'h0, 4'h0);
    `CHK(servo_fault_output, 1'b0)
    raise(12'h401, 2'h0);
    wait_n(12);
    `CHK(servo_fault_output, 1'b1)
    h_keep <= 1'b0;
    wait_n(12);
  endtask : t_held

  task automatic t_irq_erase;
    logic [DATA_W-1:0] d;
    wr_reg(REG_IRQ_STAT, 32'hF);
    wr_reg(REG_IRQ_MASK, 32'h1);
    raise(12'h500, 2'h0);
    `CHK(irq, 1'b1)
    wr_reg(REG_IRQ_STAT, 32'h1);
    wait_n(3);
    `CHK(irq, 1'b0)
    wr_reg(REG_IRQ_MASK, 32'h0);
    wr_reg(REG_CTRL, 32'h1);
    wr_reg(REG_CMD, 32'h2);
    get_slot(0, d);
    get_slot(0, d);
    `CHK(d[13:0], 14'h500)
    rd_reg(REG_IRQ_STAT, d);
    `CHK(d[EV_REFUSED], 1'b1)
    wr_reg(REG_CTRL, 32'h0);
    wr_reg(REG_CMD, 32'h2);
    get_slot(0, d);
    `CHK(d, 32'h0)
    get_slot(9, d);
    `CHK(d, 32'h0)
  endtask : t_irq_erase

  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_log;
    t_repeat;
    t_pin;
    t_keys;
    t_held;
    t_irq_erase;
    finish_test;
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    finish_test;
  end
endmodule : testbench
`default_nettype wire
